// [hdl/lrc_cnt_if.sv]
// Increment, clear and value of one error counter
`timescale 1ns/100ps
`include "lrc_defs.svh"
interface lrc_cnt_if;
  logic inc;
  logic clr;
  logic [`LRC_CNT_W-1:0] value;
  modport ctrl (output inc, output clr, input value);
  modport cnt (input inc, input clr, output value);
endinterface

// [hdl/lrc_defs.svh]
// Constants for the link reset and error control block
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH

// Register offsets (byte addresses)
`define LRC_ADDR_W 8
`define LRC_OFS_CTRL 8'h00
`define LRC_OFS_STATUS 8'h04
`define LRC_OFS_LINK_ERR 8'h08
`define LRC_OFS_SOFT_ERR 8'h0C
`define LRC_OFS_U1_TIMEOUT 8'h10
`define LRC_OFS_U2_TIMEOUT 8'h14
`define LRC_OFS_PM_TIMER 8'h18

// Control register fields (write-one pulses)
`define LRC_CTRL_PORT_RESET 0
`define LRC_CTRL_WARM_RESET 1
`define LRC_CTRL_CLR_INACTIVE 2

// Status register fields
`define LRC_STS_STATE_LSB 0
`define LRC_STS_HOT_PEND 4
`define LRC_STS_WARM_ACT 5
`define LRC_STS_LAST_HOT 6
`define LRC_STS_LAST_WARM 7

// Widths and reset values
`define LRC_CNT_W 8
`define LRC_TO_W 8
`define LRC_PMT_W 16
`define LRC_CNT_RST 8'h00
`define LRC_TO_RST 8'h00
`define LRC_PMT_RST 16'h0000

`endif

// [hdl/lrc_err_counter.sv]
// Saturating error counter with synchronous clear
`timescale 1ns/100ps
`include "lrc_defs.svh"
module lrc_err_counter
  import lrc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  lrc_cnt_if.cnt cnt_if
);

  // Clear wins over increment; the count saturates instead of wrapping to look clean
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_if.value <= `LRC_CNT_RST;
    end else if (ce) begin
      if (cnt_if.clr) begin
        cnt_if.value <= `LRC_CNT_RST;
      end else if (cnt_if.inc && (cnt_if.value != {`LRC_CNT_W{1'b1}})) begin
        cnt_if.value <= cnt_if.value + `LRC_CNT_W'(1);
      end
    end
  end

endmodule // lrc_err_counter

// [hdl/lrc_pkg.sv]
// Types shared by the link reset and error control block
package lrc_pkg;

  // Link training state as seen by reset control
  typedef enum logic [3:0] {
    ST_RXDET,
    ST_POLLING,
    ST_U0,
    ST_U1,
    ST_U2,
    ST_U3,
    ST_RECOVERY,
    ST_HOTRESET,
    ST_LOOPBACK,
    ST_COMPLIANCE,
    ST_INACTIVE,
    ST_DISABLED
  } lrc_state_type;

endpackage

// [hdl/lrc_top.sv]
// Link reset selection, inband reset sequencing and error counting
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "lrc_defs.svh"
module lrc_top
  import lrc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic is_downstream,
  input wire logic ss_plus,
  input wire logic vbus_valid,
  input wire logic [`LRC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic goto_vld,
  input wire logic [3:0] goto_state,
  input wire logic ev_rx_found,
  input wire logic ev_train_done,
  input wire logic ev_ts_timeout,
  input wire logic ev_lfps_ok,
  input wire logic ev_lfps_timeout,
  input wire logic ev_warm_done,
  input wire logic ev_warm_detect,
  input wire logic ev_ts2_reset_rx,
  input wire logic ev_partner_gone,
  input wire logic ev_poll_idle,
  input wire logic ev_err_recovery,
  input wire logic ev_inv_lcmd,
  input wire logic ev_miss_lcmd,
  input wire logic miss_ack_credit,
  input wire logic ev_blk_single,
  input wire logic ev_blk_double,
  input wire logic ev_skp_single,
  output logic [3:0] link_state,
  output logic tx_ts2_reset,
  output logic tx_warm_reset,
  output logic lfps_exit_req,
  output logic phy_defaults,
  output logic phy_retrain,
  output logic cfg_defaults,
  output logic warm_det_en,
  output logic hot_reset_done,
  output logic warm_reset_done
);

  lrc_state_type state;
  lrc_state_type next_state;
  logic init_pend;
  logic hot_pend;
  logic next_hot_pend;
  logic warm_act;
  logic next_warm_act;
  logic recov_pend;
  logic last_hot;
  logic last_warm;
  logic hot_done_now;
  logic warm_done_now;
  logic ufp_warm_now;
  logic wr_ctrl;
  logic port_req;
  logic warm_req;
  logic clr_inact;
  logic [`LRC_TO_W-1:0] u1_timeout;
  logic [`LRC_TO_W-1:0] u2_timeout;
  logic [`LRC_PMT_W-1:0] pm_timer;

  lrc_cnt_if link_cnt ();
  lrc_cnt_if soft_cnt ();

  // Software requests are taken in the write cycle itself
  assign wr_ctrl = reg_wr && (reg_addr == `LRC_OFS_CTRL);
  assign port_req = wr_ctrl && reg_wdata[`LRC_CTRL_PORT_RESET] && is_downstream;
  assign warm_req = wr_ctrl && reg_wdata[`LRC_CTRL_WARM_RESET] && is_downstream;
  assign clr_inact = wr_ctrl && reg_wdata[`LRC_CTRL_CLR_INACTIVE];

  // Next link state; directed resets outrank link events
  always_comb begin
    next_state = state;
    next_hot_pend = hot_pend;
    next_warm_act = warm_act;
    hot_done_now = 1'b0;
    warm_done_now = 1'b0;
    ufp_warm_now = 1'b0;
    if (init_pend) begin
      next_state = ST_RXDET;
    end else if (warm_req && (state != ST_DISABLED)) begin
      next_state = ST_RXDET;
      next_warm_act = 1'b1;
      next_hot_pend = 1'b0;
    end else if (port_req) begin
      // Type picked from the state held right now
      case (state)
        ST_U3, ST_LOOPBACK, ST_COMPLIANCE, ST_INACTIVE: begin
          next_state = ST_RXDET;
          next_warm_act = 1'b1;
        end
        ST_U0, ST_POLLING, ST_RECOVERY: begin
          next_state = ST_HOTRESET;
        end
        ST_U1, ST_U2: begin
          next_hot_pend = 1'b1;
        end
        default: begin
          next_state = state;
        end
      endcase
    end else if (!is_downstream && ev_warm_detect && (state != ST_DISABLED)) begin
      next_state = ST_RXDET;
      ufp_warm_now = 1'b1;
    end else begin
      if (goto_vld) begin
        next_state = lrc_state_type'(goto_state);
      end
      case (state)
        ST_RXDET: begin
          if (warm_act) begin
            if (ev_warm_done) begin
              next_warm_act = 1'b0;
              warm_done_now = 1'b1;
            end
            next_state = ST_RXDET;
          end else if (ev_rx_found) begin
            next_state = ST_POLLING;
          end
        end
        ST_POLLING: begin
          if (ev_ts2_reset_rx && !is_downstream) begin
            next_state = ST_HOTRESET;
          end else if (ev_train_done) begin
            next_state = ST_U0;
          end else if (ev_ts_timeout) begin
            next_state = ST_RXDET;
          end
        end
        ST_U0: begin
          if (ev_ts2_reset_rx && !is_downstream) begin
            next_state = ST_HOTRESET;
          end else if (ev_err_recovery || ev_blk_double || recov_pend) begin
            next_state = ST_RECOVERY;
          end
        end
        ST_U1, ST_U2: begin
          if (hot_pend && ev_lfps_ok) begin
            next_state = ST_RECOVERY;
          end else if (hot_pend && ev_lfps_timeout) begin
            next_state = ST_INACTIVE;
            next_hot_pend = 1'b0;
          end
        end
        ST_RECOVERY: begin
          if (ev_ts2_reset_rx && !is_downstream) begin
            next_state = ST_HOTRESET;
          end else if (ev_train_done) begin
            next_state = hot_pend ? ST_HOTRESET : ST_U0;
            next_hot_pend = 1'b0;
          end else if (ev_ts_timeout) begin
            next_state = (hot_pend && is_downstream) ? ST_RXDET : ST_INACTIVE;
            next_warm_act = hot_pend && is_downstream;
            next_hot_pend = 1'b0;
          end
        end
        ST_HOTRESET: begin
          if (ev_train_done) begin
            next_state = ST_U0;
            hot_done_now = 1'b1;
          end else if (ev_ts_timeout && is_downstream) begin
            next_state = ST_RXDET;
            next_warm_act = 1'b1;
          end
        end
        ST_INACTIVE: begin
          if (clr_inact || ev_partner_gone) begin
            next_state = ST_RXDET;
          end
        end
        default: begin
          next_state = next_state;
        end
      endcase
    end
  end

  // Link state and reset sequencing flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_RXDET;
      hot_pend <= 1'b0;
      warm_act <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      hot_pend <= next_hot_pend;
      warm_act <= next_warm_act;
    end
  end

  // Power-on initialisation waits for bus power before leaving receiver-detect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_pend <= 1'b1;
    end else if (ce && vbus_valid) begin
      init_pend <= 1'b0;
    end
  end

  // Delayed recovery after a lost ack or credit; the loss is counted by the link error counter, not here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      recov_pend <= 1'b0;
    end else if (ce) begin
      if (ev_miss_lcmd && miss_ack_credit) begin
        recov_pend <= 1'b1;
      end else if (next_state == ST_RECOVERY || next_state == ST_RXDET) begin
        recov_pend <= 1'b0;
      end
    end
  end

  // Which hot reset or downstream-port warm reset ran last, for software
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_hot <= 1'b0;
      last_warm <= 1'b0;
    end else if (ce) begin
      if (next_state == ST_HOTRESET && state != ST_HOTRESET) begin
        last_hot <= 1'b1;
        last_warm <= 1'b0;
      end else if (next_warm_act && !warm_act) begin
        last_hot <= 1'b0;
        last_warm <= 1'b1;
      end
    end
  end

  // Link pins and completion pulses, all registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_state <= 4'h0;
      tx_ts2_reset <= 1'b0;
      tx_warm_reset <= 1'b0;
      lfps_exit_req <= 1'b0;
      phy_defaults <= 1'b0;
      phy_retrain <= 1'b0;
      cfg_defaults <= 1'b0;
      warm_det_en <= 1'b0;
      hot_reset_done <= 1'b0;
      warm_reset_done <= 1'b0;
    end else if (ce) begin
      link_state <= 4'(next_state);
      tx_ts2_reset <= (next_state == ST_HOTRESET) && is_downstream;
      tx_warm_reset <= next_warm_act && is_downstream;
      lfps_exit_req <= next_hot_pend && (next_state == ST_U1 || next_state == ST_U2);
      phy_defaults <= init_pend && vbus_valid;
      phy_retrain <= warm_done_now || ufp_warm_now;
      cfg_defaults <= ufp_warm_now;
      warm_det_en <= !is_downstream && (next_state != ST_DISABLED);
      hot_reset_done <= hot_done_now;
      warm_reset_done <= warm_done_now || ufp_warm_now;
    end
  end

  // Error counters; link count is kept by the downstream port only
  assign link_cnt.inc = is_downstream && (ev_err_recovery || ev_blk_double || ev_miss_lcmd);
  assign link_cnt.clr = (is_downstream && (hot_done_now || warm_done_now)) || ev_poll_idle;
  assign soft_cnt.inc = ev_inv_lcmd || ev_blk_single || ev_skp_single;
  assign soft_cnt.clr = hot_done_now && ss_plus;

  lrc_err_counter u_link_cnt (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .cnt_if(link_cnt.cnt)
  );

  lrc_err_counter u_soft_cnt (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .cnt_if(soft_cnt.cnt)
  );

  // Timeout values written by software, zeroed by a finished hot reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      u1_timeout <= `LRC_TO_RST;
      u2_timeout <= `LRC_TO_RST;
    end else if (ce) begin
      if (hot_done_now) begin
        u1_timeout <= `LRC_TO_RST;
        u2_timeout <= `LRC_TO_RST;
      end else if (reg_wr && reg_addr == `LRC_OFS_U1_TIMEOUT) begin
        u1_timeout <= reg_wdata[`LRC_TO_W-1:0];
      end else if (reg_wr && reg_addr == `LRC_OFS_U2_TIMEOUT) begin
        u2_timeout <= reg_wdata[`LRC_TO_W-1:0];
      end
    end
  end

  // Idle time in U0; saturates so a long idle never reads as short
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pm_timer <= `LRC_PMT_RST;
    end else if (ce) begin
      if (hot_done_now || state != ST_U0) begin
        pm_timer <= `LRC_PMT_RST;
      end else if (pm_timer != {`LRC_PMT_W{1'b1}}) begin
        pm_timer <= pm_timer + `LRC_PMT_W'(1);
      end
    end
  end

  // Read data valid the cycle after the strobe only; unmapped reads return zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `LRC_OFS_STATUS: begin
            reg_rdata <= {24'h000000, last_warm, last_hot, warm_act, hot_pend, 4'(state)};
          end
          `LRC_OFS_LINK_ERR: begin
            reg_rdata <= {24'h000000, link_cnt.value};
          end
          `LRC_OFS_SOFT_ERR: begin
            reg_rdata <= {24'h000000, soft_cnt.value};
          end
          `LRC_OFS_U1_TIMEOUT: begin
            reg_rdata <= {24'h000000, u1_timeout};
          end
          `LRC_OFS_U2_TIMEOUT: begin
            reg_rdata <= {24'h000000, u2_timeout};
          end
          `LRC_OFS_PM_TIMER: begin
            reg_rdata <= {16'h0000, pm_timer};
          end
          default: begin
            reg_rdata <= 32'h00000000;
          end
        endcase
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_PORT_RESET_WARM: assert property (
    (ce && port_req && !init_pend && !warm_req && (state == ST_U3 || state == ST_INACTIVE))
      |=> (state == ST_RXDET) && warm_act)
    else $error("port reset in U3 or inactive did not start warm reset");

  AST_PORT_RESET_HOT: assert property (
    (ce && port_req && !init_pend && !warm_req && state == ST_U0) |=> state == ST_HOTRESET ##0 tx_ts2_reset)
    else $error("port reset in U0 did not enter hot reset");

  AST_U1_EXIT_REQ: assert property (
    (ce && port_req && !init_pend && !warm_req && state == ST_U1 && !goto_vld) |=> hot_pend && lfps_exit_req)
    else $error("port reset in U1 did not request low-power exit");

  AST_LFPS_TIMEOUT: assert property (
    (ce && state == ST_U1 && hot_pend && !ev_lfps_ok && ev_lfps_timeout && !port_req && !warm_req
      && !init_pend) |=> state == ST_INACTIVE && !hot_pend)
    else $error("exit handshake timeout did not give inactive");

  AST_DISABLED_NO_RESET: assert property (
    (ce && state == ST_DISABLED && (port_req || warm_req)) |=> !tx_warm_reset && !tx_ts2_reset)
    else $error("inband reset issued from disabled state");

  // Both outputs load at one edge; the edge that left reset still shows reset values
  AST_UFP_WARM_DET: assert property (
    !is_downstream && $past(nrst) |-> warm_det_en == (link_state != 4'(ST_DISABLED)))
    else $error("warm reset detector enable wrong");

  AST_HOT_CLEARS_TO: assert property (
    (ce && hot_done_now) |=> u1_timeout == `LRC_TO_RST && u2_timeout == `LRC_TO_RST && pm_timer == `LRC_PMT_RST)
    else $error("hot reset left timeout values set");

  AST_LINK_CLR: assert property (
    (ce && is_downstream && (hot_done_now || warm_done_now)) |=> link_cnt.value == `LRC_CNT_RST)
    else $error("link error count not cleared after inband reset");

  AST_INV_LCMD: assert property (
    (ce && ev_inv_lcmd && !ev_miss_lcmd && !ev_err_recovery && !ev_blk_double && !link_cnt.clr)
      |=> $stable(link_cnt.value))
    else $error("invalid link command changed link error count");

  AST_HOT_TO_U0: assert property (
    (ce && hot_done_now && !init_pend) |=> state == ST_U0 ##0 hot_reset_done && !cfg_defaults)
    else $error("hot reset completion did not give U0");

endmodule // lrc_top

// [tb/link_reset_and_error_control_tb.sv]
// Self-checking bench for the link reset and error control block
`timescale 1ns/100ps
`include "lrc_defs.svh"
module link_reset_and_error_control_tb
  import lrc_pkg::*;
;
  localparam int WDET = 0, TS2RX = 1, GONE = 2, PIDLE = 3, ERREC = 4, INV = 5, MISS = 6, BLK1 = 7;
  localparam int BLK2 = 8, SKP = 9, RXF = 10;
  logic clk, nrst, ce, dsp, ss_plus, vbus, wr, rd, goto_vld, miss_ack;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] goto_state, link_state;
  logic [10:0] ev;
  logic [1:0] mode;
  logic [4:0] seen;
  logic tx_ts2_reset, tx_warm_reset, lfps_exit_req, phy_defaults, phy_retrain, cfg_defaults, warm_det_en;
  logic hot_reset_done, warm_reset_done, p_train, p_tsto, p_lok, p_lto, p_wdone;
  int err_count, check_count, cycles, clr_tick, clr_done;

  lrc_top uut (.clk(clk), .nrst(nrst), .ce(ce), .is_downstream(dsp), .ss_plus(ss_plus), .vbus_valid(vbus),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .goto_vld(goto_vld),
    .goto_state(goto_state), .ev_rx_found(ev[RXF]), .ev_train_done(p_train), .ev_ts_timeout(p_tsto),
    .ev_lfps_ok(p_lok), .ev_lfps_timeout(p_lto), .ev_warm_done(p_wdone), .ev_warm_detect(ev[WDET]),
    .ev_ts2_reset_rx(ev[TS2RX]), .ev_partner_gone(ev[GONE]), .ev_poll_idle(ev[PIDLE]),
    .ev_err_recovery(ev[ERREC]), .ev_inv_lcmd(ev[INV]), .ev_miss_lcmd(ev[MISS]), .miss_ack_credit(miss_ack),
    .ev_blk_single(ev[BLK1]), .ev_blk_double(ev[BLK2]), .ev_skp_single(ev[SKP]), .link_state(link_state),
    .tx_ts2_reset(tx_ts2_reset), .tx_warm_reset(tx_warm_reset), .lfps_exit_req(lfps_exit_req),
    .phy_defaults(phy_defaults), .phy_retrain(phy_retrain), .cfg_defaults(cfg_defaults),
    .warm_det_en(warm_det_en), .hot_reset_done(hot_reset_done), .warm_reset_done(warm_reset_done));

  lrc_partner_model partner (.clk(clk), .nrst(nrst), .mode(mode), .link_state(link_state),
    .tx_warm_reset(tx_warm_reset), .lfps_exit_req(lfps_exit_req), .ev_train_done(p_train),
    .ev_ts_timeout(p_tsto), .ev_lfps_ok(p_lok), .ev_lfps_timeout(p_lto), .ev_warm_done(p_wdone));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Sticky record of one-cycle pulses; a bump of clr_tick restarts it, so only this block writes it
  always @(posedge clk) begin
    seen <= ((clr_tick != clr_done) ? 5'h00 : seen)
      | {phy_defaults, cfg_defaults, phy_retrain, warm_reset_done, hot_reset_done};
    clr_done <= clr_tick;
  end

  // Hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic go(input lrc_state_type s);
    @(posedge clk);
    goto_vld <= 1'b1;
    goto_state <= s;
    @(posedge clk);
    goto_vld <= 1'b0;
    #1;
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    #1;
  endtask

  // Bounded wait for a state; a missed state shows as a mismatch
  task automatic wait_state(input lrc_state_type s);
    int n;
    n = 0;
    while (link_state !== s && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(link_state, s);
  endtask

  task automatic wait_seen(input int i);
    int n;
    n = 0;
    while (seen[i] !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(seen[i], 1'b1);
  endtask

  initial begin
    lrc_state_type warm_st[4];
    lrc_state_type hot_st[2];
    warm_st = '{ST_U3, ST_LOOPBACK, ST_COMPLIANCE, ST_INACTIVE};
    hot_st = '{ST_POLLING, ST_RECOVERY};
    {nrst, wr, rd, goto_vld, miss_ack, vbus} = 6'h02;
    {ce, dsp, ss_plus} = 3'h7;
    addr = 8'h00;
    wdata = 32'h00000000;
    goto_state = 4'h0;
    ev = 11'h000;
    mode = 2'h0;
    clr_tick = 1;
    err_count = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    vbus <= 1'b1;
    wait_seen(4);
    chk(link_state, ST_RXDET);
    go(ST_U0);
    repeat (20) @(posedge clk);
    #1;
    chk({tx_ts2_reset, tx_warm_reset, lfps_exit_req}, 3'h0);
    // Error classes and which count each one moves
    pulse(INV);
    rd_chk(`LRC_OFS_LINK_ERR, 32'h00000000);
    rd_chk(`LRC_OFS_SOFT_ERR, 32'h00000001);
    pulse(MISS);
    rd_chk(`LRC_OFS_LINK_ERR, 32'h00000001);
    wait_state(ST_RECOVERY);
    pulse(BLK1);
    pulse(SKP);
    rd_chk(`LRC_OFS_SOFT_ERR, 32'h00000003);
    rd_chk(`LRC_OFS_LINK_ERR, 32'h00000001);
    pulse(ERREC);
    pulse(BLK2);
    rd_chk(`LRC_OFS_LINK_ERR, 32'h00000003);
    wr_reg(`LRC_OFS_U1_TIMEOUT, 32'h0000005A);
    wr_reg(`LRC_OFS_U2_TIMEOUT, 32'h000000A5);
    rd_chk(`LRC_OFS_U1_TIMEOUT, 32'h0000005A);
    rd_chk(`LRC_OFS_U2_TIMEOUT, 32'h000000A5);
    // Port reset from U0 is a hot reset that clears counts and timeouts
    go(ST_U0);
    wr_reg(`LRC_OFS_CTRL, 32'h00000001);
    chk(link_state, ST_HOTRESET);
    chk({tx_ts2_reset, tx_warm_reset}, 2'h2);
    wait_state(ST_U0);
    chk({phy_retrain, warm_reset_done, hot_reset_done}, 3'h1);
    rd_chk(`LRC_OFS_LINK_ERR, 32'h00000000);
    rd_chk(`LRC_OFS_SOFT_ERR, 32'h00000000);
    rd_chk(`LRC_OFS_U1_TIMEOUT, 32'h00000000);
    rd_chk(`LRC_OFS_U2_TIMEOUT, 32'h00000000);
    // States where a port reset must become a warm reset
    foreach (warm_st[i]) begin
      go(warm_st[i]);
      pulse(ERREC);
      clr_tick++;
      wr_reg(`LRC_OFS_CTRL, 32'h00000001);
      chk({tx_ts2_reset, tx_warm_reset}, 2'h1);
      wait_seen(1);
      chk(seen[2], 1'b1);
      chk(link_state, ST_RXDET);
      rd_chk(`LRC_OFS_LINK_ERR, 32'h00000000);
    end
    pulse(ERREC);
    pulse(PIDLE);
    rd_chk(`LRC_OFS_LINK_ERR, 32'h00000000);
    // Transitory states take a hot reset; the partner answers slowly here
    mode = 2'h1;
    foreach (hot_st[i]) begin
      go(hot_st[i]);
      wr_reg(`LRC_OFS_CTRL, 32'h00000001);
      chk(link_state, ST_HOTRESET);
      wait_state(ST_U0);
    end
    mode = 2'h0;
    // Low-power states leave by the exit handshake, then recovery, then hot reset
    for (int i = 0; i < 2; i++) begin
      go(i ? ST_U2 : ST_U1);
      wr_reg(`LRC_OFS_CTRL, 32'h00000001);
      chk(lfps_exit_req, 1'b1);
      wait_state(ST_RECOVERY);
      wait_state(ST_HOTRESET);
      wait_state(ST_U0);
    end
    mode = 2'h2;
    go(ST_U2);
    wr_reg(`LRC_OFS_CTRL, 32'h00000001);
    wait_state(ST_INACTIVE);
    repeat (20) @(posedge clk);
    #1;
    chk(link_state, ST_INACTIVE);
    wr_reg(`LRC_OFS_CTRL, 32'h00000004);
    chk(link_state, ST_RXDET);
    mode = 2'h3;
    go(ST_U1);
    wr_reg(`LRC_OFS_CTRL, 32'h00000001);
    wait_state(ST_RECOVERY);
    wait_state(ST_RXDET);
    chk(tx_warm_reset, 1'b1);
    mode = 2'h0;
    clr_tick++;
    wait_seen(1);
    go(ST_U0);
    clr_tick++;
    wr_reg(`LRC_OFS_CTRL, 32'h00000002);
    chk({link_state, tx_warm_reset}, {ST_RXDET, 1'b1});
    wait_seen(1);
    go(ST_DISABLED);
    wr_reg(`LRC_OFS_CTRL, 32'h00000001);
    wr_reg(`LRC_OFS_CTRL, 32'h00000002);
    repeat (10) @(posedge clk);
    #1;
    chk({link_state, tx_ts2_reset, tx_warm_reset, lfps_exit_req}, {ST_DISABLED, 3'h0});
    // Second reset: the same block as an upstream-facing port
    nrst <= 1'b0;
    dsp <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    go(ST_U0);
    chk(warm_det_en, 1'b1);
    wr_reg(`LRC_OFS_CTRL, 32'h00000001);
    wr_reg(`LRC_OFS_CTRL, 32'h00000002);
    chk({link_state, tx_ts2_reset, tx_warm_reset, lfps_exit_req}, {ST_U0, 3'h0});
    pulse(ERREC);
    rd_chk(`LRC_OFS_LINK_ERR, 32'h00000000);
    // Outside 128b/132b operation a hot reset keeps the soft count
    ss_plus <= 1'b0;
    pulse(INV);
    pulse(TS2RX);
    chk(link_state, ST_HOTRESET);
    wait_state(ST_U0);
    chk({cfg_defaults, phy_retrain, warm_reset_done, hot_reset_done}, 4'h1);
    rd_chk(`LRC_OFS_SOFT_ERR, 32'h00000001);
    pulse(WDET);
    chk(link_state, ST_RXDET);
    chk({cfg_defaults, phy_retrain}, 2'h3);
    go(ST_DISABLED);
    chk(warm_det_en, 1'b0);
    stop_test();
  end
endmodule // link_reset_and_error_control_tb

// [tb/lrc_partner_model.sv]
// Behavioural link partner answering the reset handshakes of the block
`timescale 1ns/100ps
module lrc_partner_model
  import lrc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] mode,
  input wire logic [3:0] link_state,
  input wire logic tx_warm_reset,
  input wire logic lfps_exit_req,
  output logic ev_train_done,
  output logic ev_ts_timeout,
  output logic ev_lfps_ok,
  output logic ev_lfps_timeout,
  output logic ev_warm_done
);
  logic [5:0] last;
  logic [4:0] wait_cnt;
  logic done;

  // One answer per handshake; mode 1 answers slowly, 2 and 3 let a handshake time out
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last <= 6'h00;
      wait_cnt <= 5'h00;
      done <= 1'b0;
      {ev_train_done, ev_ts_timeout, ev_lfps_ok, ev_lfps_timeout, ev_warm_done} <= 5'h00;
    end else begin
      {ev_train_done, ev_ts_timeout, ev_lfps_ok, ev_lfps_timeout, ev_warm_done} <= 5'h00;
      last <= {link_state, tx_warm_reset, lfps_exit_req};
      if (last != {link_state, tx_warm_reset, lfps_exit_req}) begin
        wait_cnt <= 5'h00;
        done <= 1'b0;
      end else if (!done && wait_cnt == ((mode == 2'h1) ? 5'h0C : 5'h03)) begin
        done <= 1'b1;
        if (lfps_exit_req) begin
          ev_lfps_timeout <= (mode == 2'h2);
          ev_lfps_ok <= (mode != 2'h2);
        end else if (tx_warm_reset) begin
          ev_warm_done <= 1'b1;
        end else if (link_state == ST_RECOVERY) begin
          ev_ts_timeout <= (mode == 2'h3);
          ev_train_done <= (mode != 2'h3);
        end else if (link_state == ST_HOTRESET) begin
          ev_train_done <= 1'b1;
        end
      end else if (!done) begin
        wait_cnt <= wait_cnt + 5'h01;
      end
    end
  end
endmodule // lrc_partner_model
